// ==== tb/gfm_board_model.sv ====
/*
  Board-side model of the four general-purpose pins: external logic that
  drives a pin only while the device leaves it undriven.
  Assumes pins are sampled in the clk domain; no pull resistors fitted.
*/
`timescale 1ns/1ps
module gfm_board_model (
  input wire logic clk,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe_n,
  input wire logic [3:0] board_lvl,
  input wire logic [3:0] board_en,
  output logic [3:0] pin_in
);
  logic float_r = 1'b0; // Level of an undriven wire, toggles every cycle

  // No pull-up: a released wire must not look like a stable level
  always @(posedge clk) begin
    float_r <= ~float_r;
  end

  // Wire resolution, device drive wins over the board
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!pin_oe_n[i]) begin
        pin_in[i] = pin_out[i];
      end else if (board_en[i]) begin
        pin_in[i] = board_lvl[i];
      end else begin
        pin_in[i] = float_r;
      end
    end
  end
endmodule

// ==== tb/gpio_function_mux_tb_top.sv ====
/*
  Self-checking bench for the pin function block: register access,
  input and output functions, direction and reset behaviour.
  Assumes the design files and the board model are compiled first.
*/
`timescale 1ns/1ps
module gpio_function_mux_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [9:0] reg_addr = 10'h000;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [3:0] pin_in;
  logic [3:0] pin_out;
  logic [3:0] pin_oe_n;
  logic [3:0] flags = 4'h0; // Lock loss, ref0 loss, ref1 loss, holdover
  logic [1:0] output_enable_select;
  logic manual_reference_select;
  logic [3:0] board_lvl = 4'h0; // Levels the board applies
  logic [3:0] board_en = 4'h0; // Pins the board drives
  int n_errors = 0;
  int num_checks = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  gfm_top DUT (
    .clk(clk),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .holdover_flag(flags[0]),
    .ref1_los_flag(flags[1]),
    .ref0_los_flag(flags[2]),
    .lock_loss_flag(flags[3]),
    .output_enable_select(output_enable_select),
    .manual_reference_select(manual_reference_select)
  );

  gfm_board_model board (
    .clk(clk),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .board_lvl(board_lvl),
    .board_en(board_en),
    .pin_in(pin_in)
  );

  // Closing report, also reached by the watchdog
  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Register read data compare
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Pin or select level compare
  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // All tasks enter and leave 1 ns after a rising edge
  task automatic do_reset(input int n);
    rstn = 1'b0;
    // Direction address on the port so the release read is checked
    reg_addr = 10'h030;
    repeat (n) @(posedge clk);
    #1;
    rstn = 1'b1;
  endtask

  // One-cycle write strobe, then an idle edge so strobes never merge
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask

  // Address held two edges so either read latency reading is covered
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
    reg_addr = a;
    repeat (2) @(posedge clk);
    #1;
    chk_reg(reg_rdata, exp);
  endtask

  // Let register, mux and pin stages land
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Reset values of every writable register, reserved and unmapped reads
  task automatic t_reset_values();
    settle();
    chk_pin(pin_oe_n, 4'hF);
    chk_pin(pin_out, 4'h0);
    rd_chk(10'h030, 8'h00);
    rd_chk(10'h031, 8'h00);
    rd_chk(10'h032, 8'h00);
    rd_chk(10'h033, 8'h0F);
    rd_chk(10'h034, 8'h00);
    rd_chk(10'h035, 8'h00);
    rd_chk(10'h036, 8'h00);
    rd_chk(10'h037, 8'h00);
    rd_chk(10'h038, 8'h00);
    rd_chk(10'h100, 8'h00);
  endtask

  // Reset codes route pins 0..2 to control selects, none to the register
  task automatic t_input_special();
    logic [3:0] v;
    board_en = 4'hF;
    for (int k = 0; k < 2; k++) begin
      v = (k == 0) ? 4'h5 : 4'hA;
      board_lvl = v;
      settle();
      chk_pin({2'b00, output_enable_select}, {2'b00, v[1:0]});
      chk_pin({3'b000, manual_reference_select}, {3'b000, v[2]});
      chk_pin(pin_oe_n, 4'hF);
    end
    rd_chk(10'h20C, 8'h00);
  endtask

  // General inputs, selects holding, codes built MSB first
  task automatic t_input_general();
    wr(10'h033, 8'h00);
    board_lvl = 4'h9;
    settle();
    rd_chk(10'h20C, 8'h09);
    chk_pin({2'b00, output_enable_select}, 4'h2);
    board_lvl = 4'h6;
    wr(10'h031, 8'h04);
    settle();
    rd_chk(10'h20C, 8'h02);
    chk_pin({3'b000, manual_reference_select}, 4'h0);
    wr(10'h031, 8'h00);
    wr(10'h033, 8'h04);
    settle();
    rd_chk(10'h20C, 8'h02);
    chk_pin({3'b000, manual_reference_select}, 4'h1);
  endtask

  // Output mode: software values, status flags, reserved codes
  task automatic t_outputs();
    board_en = 4'h0;
    wr(10'h030, 8'h0F);
    wr(10'h038, 8'h0A);
    settle();
    chk_pin(pin_oe_n, 4'h0);
    chk_pin(pin_out, 4'hA);
    rd_chk(10'h038, 8'h0A);
    rd_chk(10'h20C, 8'h00);
    wr(10'h036, 8'h0F);
    flags = 4'h5;
    settle();
    chk_pin(pin_out, 4'h5);
    flags = 4'hA;
    settle();
    chk_pin(pin_out, 4'hA);
    wr(10'h035, 8'h0F);
    settle();
    chk_pin(pin_out, 4'h0);
    wr(10'h036, 8'h00);
    wr(10'h035, 8'h00);
    wr(10'h034, 8'h0F);
    settle();
    chk_pin(pin_out, 4'h0);
    wr(10'h034, 8'h00);
  endtask

  // Mixed directions: input pins stay undriven and readable
  task automatic t_mixed();
    wr(10'h030, 8'h05);
    wr(10'h038, 8'h0F);
    board_en = 4'hA;
    board_lvl = 4'hA;
    settle();
    chk_pin(pin_oe_n, 4'hA);
    chk_pin(pin_out & 4'h5, 4'h5);
    rd_chk(10'h20C, 8'h0A);
  endtask

  // Main sequence
  initial begin
    do_reset(16);
    t_reset_values();
    t_input_special();
    t_input_general();
    t_outputs();
    t_mixed();
    do_reset(2);
    t_reset_values();
    complete_run();
  end

  // Watchdog, well beyond the 140 or so cycles the tests need
  initial begin
    #50000;
    n_errors++;
    complete_run();
  end
endmodule

// ==== verilog/gfm_pin_mux.sv ====
/*
  Per-pin function mux: picks general or special function for input
  and output mode and drives the pin enables.
  Assumes flags and pins are already synchronous to clk.
*/
`timescale 1ns/1ps
module gfm_pin_mux (
  gfm_sel_if.mux sel,
  input wire logic [3:0] pin_in,
  input wire logic [3:0] status_flags,
  output logic [3:0] pin_out_nxt,
  output logic [3:0] pin_oe_n_nxt,
  output logic [1:0] oe_sel_nxt,
  output logic oe_sel_valid_nxt_0,
  output logic oe_sel_valid_nxt_1,
  output logic ref_sel_nxt,
  output logic ref_sel_valid_nxt
);
  // Assemble a pin's 3-bit code, MSB from the lowest address
  function automatic logic [2:0] code_of(input logic [3:0] b2,
    input logic [3:0] b1, input logic [3:0] b0, input int i);
    code_of = {b2[i], b1[i], b0[i]};
  endfunction

  // Per-pin decode of both selector sets
  always_comb begin
    logic [2:0] ic;
    logic [2:0] oc;
    ic = 3'b000;
    oc = 3'b000;
    pin_out_nxt = 4'h0;
    pin_oe_n_nxt = 4'hF;
    sel.gp_in = 4'h0;
    oe_sel_nxt = 2'b00;
    oe_sel_valid_nxt_0 = 1'b0;
    oe_sel_valid_nxt_1 = 1'b0;
    ref_sel_nxt = 1'b0;
    ref_sel_valid_nxt = 1'b0;
    for (int i = 0; i < gfm_pkg::PIN_N; i++) begin
      ic = code_of(sel.sel_b2_in, sel.sel_b1_in, sel.sel_b0_in, i);
      oc = code_of(sel.sel_b2_out, sel.sel_b1_out, sel.sel_b0_out, i);
      if (sel.dir[i]) begin // Output mode
        pin_oe_n_nxt[i] = 1'b0;
        // Reserved codes drive low, a safe level
        if (oc == gfm_pkg::GFM_SEL_GENERAL) begin
          pin_out_nxt[i] = sel.out_vals[i];
        end else if (oc == gfm_pkg::GFM_SEL_SPECIAL) begin
          pin_out_nxt[i] = status_flags[i];
        end
      end else begin // Input mode, pin left undriven
        if (ic == gfm_pkg::GFM_SEL_GENERAL) begin
          sel.gp_in[i] = pin_in[i];
        end else if (ic == gfm_pkg::GFM_SEL_SPECIAL) begin
          // Pin 3 code 001 is reserved: no function
          if (i == 0) begin
            oe_sel_nxt[0] = pin_in[0];
            oe_sel_valid_nxt_0 = 1'b1;
          end else if (i == 1) begin
            oe_sel_nxt[1] = pin_in[1];
            oe_sel_valid_nxt_1 = 1'b1;
          end else if (i == 2) begin
            ref_sel_nxt = pin_in[2];
            ref_sel_valid_nxt = 1'b1;
          end
        end
      end
    end
  end
endmodule

// ==== verilog/gfm_pkg.sv ====
/*
  Package for the general-purpose pin function block: register offsets,
  field positions, reset values and selector codes.
  Assumes a byte-wide register port with 10-bit addresses.
*/
package gfm_pkg;
  // Register port widths and pin count
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int PIN_N = 4;

  // Register offsets
  localparam logic [9:0] OFF_PIN_DIRECTION = 10'h030;
  localparam logic [9:0] OFF_IN_SEL_BIT2 = 10'h031;
  localparam logic [9:0] OFF_IN_SEL_BIT1 = 10'h032;
  localparam logic [9:0] OFF_IN_SEL_BIT0 = 10'h033;
  localparam logic [9:0] OFF_OUT_SEL_BIT2 = 10'h034;
  localparam logic [9:0] OFF_OUT_SEL_BIT1 = 10'h035;
  localparam logic [9:0] OFF_OUT_SEL_BIT0 = 10'h036;
  localparam logic [9:0] OFF_RESERVED_SLOT = 10'h037;
  localparam logic [9:0] OFF_PIN_OUTPUT_VALUES = 10'h038;
  localparam logic [9:0] OFF_PIN_INPUT_VALUES = 10'h20C;

  // Reset values (4-bit fields in bits 3..0)
  localparam logic [3:0] RST_DIRECTION = 4'h0;
  localparam logic [3:0] RST_IN_SEL_BIT2 = 4'h0;
  localparam logic [3:0] RST_IN_SEL_BIT1 = 4'h0;
  localparam logic [3:0] RST_IN_SEL_BIT0 = 4'hF;
  localparam logic [3:0] RST_OUT_SEL = 4'h0;
  localparam logic [3:0] RST_OUTPUT_VALUES = 4'h0;
  localparam logic [3:0] RST_INPUT_VALUES = 4'h0;

  // Selector codes
  typedef enum logic [2:0] {
    GFM_SEL_GENERAL = 3'b000,
    GFM_SEL_SPECIAL = 3'b001
  } gfm_sel_t;
endpackage

// ==== verilog/gfm_regs.sv ====
/*
  Register file for the pin function block: byte-wide port with
  write strobe and registered read data.
  Assumes the serial configuration engine presents one access per cycle.
*/
`timescale 1ns/1ps
module gfm_regs (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [9:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  gfm_sel_if.regs sel
);
  logic [3:0] dir_r; // Direction bits
  logic [3:0] is2_r; // Input selector bit 2
  logic [3:0] is1_r; // Input selector bit 1
  logic [3:0] is0_r; // Input selector bit 0
  logic [3:0] os2_r; // Output selector bit 2
  logic [3:0] os1_r; // Output selector bit 1
  logic [3:0] os0_r; // Output selector bit 0
  logic [3:0] gpo_r; // Output levels
  logic [3:0] gpi_r; // Sampled general inputs
  logic [7:0] rdata_nxt; // Read mux

  // Writes; reserved upper bits are not stored
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dir_r <= gfm_pkg::RST_DIRECTION;
      is2_r <= gfm_pkg::RST_IN_SEL_BIT2;
      is1_r <= gfm_pkg::RST_IN_SEL_BIT1;
      is0_r <= gfm_pkg::RST_IN_SEL_BIT0; // Code 001 on all pins
      os2_r <= gfm_pkg::RST_OUT_SEL;
      os1_r <= gfm_pkg::RST_OUT_SEL;
      os0_r <= gfm_pkg::RST_OUT_SEL;
      gpo_r <= gfm_pkg::RST_OUTPUT_VALUES;
    end else if (reg_wr) begin
      unique case (reg_addr)
        gfm_pkg::OFF_PIN_DIRECTION: dir_r <= reg_wdata[3:0];
        gfm_pkg::OFF_IN_SEL_BIT2: is2_r <= reg_wdata[3:0];
        gfm_pkg::OFF_IN_SEL_BIT1: is1_r <= reg_wdata[3:0];
        gfm_pkg::OFF_IN_SEL_BIT0: is0_r <= reg_wdata[3:0];
        gfm_pkg::OFF_OUT_SEL_BIT2: os2_r <= reg_wdata[3:0];
        gfm_pkg::OFF_OUT_SEL_BIT1: os1_r <= reg_wdata[3:0];
        gfm_pkg::OFF_OUT_SEL_BIT0: os0_r <= reg_wdata[3:0];
        gfm_pkg::OFF_PIN_OUTPUT_VALUES: gpo_r <= reg_wdata[3:0];
        default: ; // Read-only, reserved and unmapped ignore writes
      endcase
    end
  end

  // Sample pins set up as general inputs each cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      gpi_r <= gfm_pkg::RST_INPUT_VALUES;
    end else begin
      gpi_r <= sel.gp_in;
    end
  end

  // Read mux; reserved and unmapped read zero
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (reg_addr)
      gfm_pkg::OFF_PIN_DIRECTION: rdata_nxt = {4'h0, dir_r};
      gfm_pkg::OFF_IN_SEL_BIT2: rdata_nxt = {4'h0, is2_r};
      gfm_pkg::OFF_IN_SEL_BIT1: rdata_nxt = {4'h0, is1_r};
      gfm_pkg::OFF_IN_SEL_BIT0: rdata_nxt = {4'h0, is0_r};
      gfm_pkg::OFF_OUT_SEL_BIT2: rdata_nxt = {4'h0, os2_r};
      gfm_pkg::OFF_OUT_SEL_BIT1: rdata_nxt = {4'h0, os1_r};
      gfm_pkg::OFF_OUT_SEL_BIT0: rdata_nxt = {4'h0, os0_r};
      gfm_pkg::OFF_PIN_OUTPUT_VALUES: rdata_nxt = {4'h0, gpo_r};
      gfm_pkg::OFF_PIN_INPUT_VALUES: rdata_nxt = {4'h0, gpi_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Registered read data, valid one cycle after the address
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

  // Fields to the mux
  assign sel.dir = dir_r;
  assign sel.sel_b2_in = is2_r;
  assign sel.sel_b1_in = is1_r;
  assign sel.sel_b0_in = is0_r;
  assign sel.sel_b2_out = os2_r;
  assign sel.sel_b1_out = os1_r;
  assign sel.sel_b0_out = os0_r;
  assign sel.out_vals = gpo_r;
endmodule

// ==== verilog/gfm_sel_if.sv ====
/*
  Interface carrying the assembled per-pin selector fields and direction
  bits from the register file to the pin mux.
  Assumes a single clock domain; the interface is purely combinational.
*/
`timescale 1ns/1ps
interface gfm_sel_if;
  logic [3:0] dir; // Direction, 1 = output
  logic [3:0] sel_b2_in; // Input selector bit 2 per pin
  logic [3:0] sel_b1_in; // Input selector bit 1 per pin
  logic [3:0] sel_b0_in; // Input selector bit 0 per pin
  logic [3:0] sel_b2_out; // Output selector bit 2 per pin
  logic [3:0] sel_b1_out; // Output selector bit 1 per pin
  logic [3:0] sel_b0_out; // Output selector bit 0 per pin
  logic [3:0] out_vals; // Software output levels
  logic [3:0] gp_in; // Pins seen as general inputs
  modport regs (output dir, sel_b2_in, sel_b1_in, sel_b0_in,
    sel_b2_out, sel_b1_out, sel_b0_out, out_vals, input gp_in);
  modport mux (input dir, sel_b2_in, sel_b1_in, sel_b0_in,
    sel_b2_out, sel_b1_out, sel_b0_out, out_vals, output gp_in);
endinterface

// ==== verilog/gfm_top.sv ====
/*
  General-purpose pin function block: four configurable pins, each an
  input routed to a register or a control function, or an output driven
  from software or a PLL status flag.
  Assumes pins, flags and the register port are synchronous to clk.
*/
// Behaviour
// - Direction bit: 0 input, 1 output; reset 0
// - Pin 0 input: 000 general, 001 enable select
// - Pin 1 input: 000 general, 001 enable select
// - Pin 2 input: 000 general, 001 reference select
// - Pin 3 input: 000 general, others reserved
// - General inputs readable in read-only input register
// - Pin 0 output: 000 value, 001 holdover flag
// - Pin 1 output: 000 value, 001 ref1 loss
// - Pin 2 output: 000 value, 001 ref0 loss
// - Pin 3 output: 000 value, 001 lock loss
// - Writable output value register, reset zero
`timescale 1ns/1ps
module gfm_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [9:0] reg_addr, // Configuration port address
  input wire logic reg_wr, // Write strobe
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data, one cycle late
  input wire logic [3:0] pin_in, // Pin input levels
  output logic [3:0] pin_out, // Pin drive levels
  output logic [3:0] pin_oe_n, // Low while the pin is driven
  input wire logic holdover_flag, // PLL in holdover
  input wire logic ref1_los_flag, // Loss of signal, reference 1
  input wire logic ref0_los_flag, // Loss of signal, reference 0
  input wire logic lock_loss_flag, // PLL lost lock
  output logic [1:0] output_enable_select, // Clock output enable select
  output logic manual_reference_select // Manual reference pick
);
  gfm_sel_if sel_i (); // Register-to-mux fields
  logic [3:0] pin_out_nxt; // Mux drive level
  logic [3:0] pin_oe_n_nxt; // Mux enable
  logic [1:0] oe_sel_nxt; // Enable select from pins
  logic oe0_v; // Pin 0 carries enable select
  logic oe1_v; // Pin 1 carries enable select
  logic ref_sel_nxt; // Reference select from pin 2
  logic ref_v; // Pin 2 carries reference select
  logic [3:0] flags; // Flag per pin

  // Flag order follows the pin that shows it
  assign flags = {lock_loss_flag, ref0_los_flag, ref1_los_flag,
    holdover_flag};

  // Per-pin codes for the checks, MSB from the lowest address
  logic [2:0] icode [gfm_pkg::PIN_N]; // Input function code
  logic [2:0] ocode [gfm_pkg::PIN_N]; // Output function code

  // Gathered once here so the checks below stay short
  always_comb begin
    for (int i = 0; i < gfm_pkg::PIN_N; i++) begin
      icode[i] = {sel_i.sel_b2_in[i], sel_i.sel_b1_in[i],
        sel_i.sel_b0_in[i]};
      ocode[i] = {sel_i.sel_b2_out[i], sel_i.sel_b1_out[i],
        sel_i.sel_b0_out[i]};
    end
  end

  gfm_regs u_regs (
    .clk(clk),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .sel(sel_i.regs)
  );

  gfm_pin_mux u_mux (
    .sel(sel_i.mux),
    .pin_in(pin_in),
    .status_flags(flags),
    .pin_out_nxt(pin_out_nxt),
    .pin_oe_n_nxt(pin_oe_n_nxt),
    .oe_sel_nxt(oe_sel_nxt),
    .oe_sel_valid_nxt_0(oe0_v),
    .oe_sel_valid_nxt_1(oe1_v),
    .ref_sel_nxt(ref_sel_nxt),
    .ref_sel_valid_nxt(ref_v)
  );

  // Pin drive registered; released at reset so nothing fights the board
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_out <= 4'h0;
      pin_oe_n <= 4'hF;
    end else begin
      pin_out <= pin_out_nxt;
      pin_oe_n <= pin_oe_n_nxt;
    end
  end

  // Control functions hold their last value when no pin feeds them
  always_ff @(posedge clk) begin
    if (!rstn) begin
      output_enable_select <= 2'b00;
      manual_reference_select <= 1'b0;
    end else begin
      if (oe0_v) begin
        output_enable_select[0] <= oe_sel_nxt[0];
      end
      if (oe1_v) begin
        output_enable_select[1] <= oe_sel_nxt[1];
      end
      if (ref_v) begin
        manual_reference_select <= ref_sel_nxt;
      end
    end
  end

  // Output-mode pin 0 with code 000 shows its value bit next cycle
  gp_output_a: assert property (@(posedge clk) disable iff (!rstn)
    (sel_i.dir[0] && sel_i.sel_b2_out[0] == 1'b0 &&
    sel_i.sel_b1_out[0] == 1'b0 && sel_i.sel_b0_out[0] == 1'b0)
    |=> (pin_out[0] == $past(sel_i.out_vals[0]) && !pin_oe_n[0]))
    else $error("pin 0 general output wrong");

  // Holdover flag on pin 0
  holdover_out_a: assert property (@(posedge clk) disable iff (!rstn)
    (sel_i.dir[0] && {sel_i.sel_b2_out[0], sel_i.sel_b1_out[0],
    sel_i.sel_b0_out[0]} == 3'b001) |=> pin_out[0] == $past(holdover_flag))
    else $error("holdover flag not on pin 0");

  // Reference 1 loss on pin 1
  ref1_los_out_a: assert property (@(posedge clk) disable iff (!rstn)
    (sel_i.dir[1] && {sel_i.sel_b2_out[1], sel_i.sel_b1_out[1],
    sel_i.sel_b0_out[1]} == 3'b001) |=> pin_out[1] == $past(ref1_los_flag))
    else $error("reference 1 loss not on pin 1");

  // Reference 0 loss on pin 2
  ref0_los_out_a: assert property (@(posedge clk) disable iff (!rstn)
    (sel_i.dir[2] && {sel_i.sel_b2_out[2], sel_i.sel_b1_out[2],
    sel_i.sel_b0_out[2]} == 3'b001) |=> pin_out[2] == $past(ref0_los_flag))
    else $error("reference 0 loss not on pin 2");

  // Lock loss on pin 3
  lock_loss_out_a: assert property (@(posedge clk) disable iff (!rstn)
    (sel_i.dir[3] && {sel_i.sel_b2_out[3], sel_i.sel_b1_out[3],
    sel_i.sel_b0_out[3]} == 3'b001) |=> pin_out[3] == $past(lock_loss_flag))
    else $error("lock loss not on pin 3");

  // Input-mode pin 2 stays undriven
  input_undriven_a: assert property (@(posedge clk) disable iff (!rstn)
    !sel_i.dir[2] |=> pin_oe_n[2])
    else $error("input pin driven");

  // Enable select bit 0 follows pin 0
  oe_select_a: assert property (@(posedge clk) disable iff (!rstn)
    (!sel_i.dir[0] && {sel_i.sel_b2_in[0], sel_i.sel_b1_in[0],
    sel_i.sel_b0_in[0]} == 3'b001)
    |=> output_enable_select[0] == $past(pin_in[0]))
    else $error("enable select 0 not from pin 0");

  // Pin 1 drives enable select bit 1
  oe_select1_a: assert property (@(posedge clk) disable iff (!rstn)
    (!sel_i.dir[1] && {sel_i.sel_b2_in[1], sel_i.sel_b1_in[1],
    sel_i.sel_b0_in[1]} == 3'b001)
    |=> output_enable_select[1] == $past(pin_in[1]))
    else $error("enable select 1 not from pin 1");

  // Reference select follows pin 2
  ref_select_a: assert property (@(posedge clk) disable iff (!rstn)
    (!sel_i.dir[2] && {sel_i.sel_b2_in[2], sel_i.sel_b1_in[2],
    sel_i.sel_b0_in[2]} == 3'b001)
    |=> manual_reference_select == $past(pin_in[2]))
    else $error("reference select not from pin 2");

  // General input on pin 3 readable two cycles later
  gp_input_read_a: assert property (@(posedge clk) disable iff (!rstn)
    (!sel_i.dir[3] && {sel_i.sel_b2_in[3], sel_i.sel_b1_in[3],
    sel_i.sel_b0_in[3]} == 3'b000 && reg_addr == 10'h20C) ##1
    (reg_addr == 10'h20C) |=> reg_rdata[3] == $past(pin_in[3], 2))
    else $error("general input 3 not readable");

  // Direction reads back zero after reset
  dir_reset_a: assert property (@(posedge clk)
    (!rstn && !reg_wr) ##1 (rstn && reg_addr == 10'h030)
    |=> reg_rdata[3:0] == 4'h0)
    else $error("direction not zero after reset");

  // Pin 1 general output shows its value bit
  gp_output1_a: assert property (@(posedge clk) disable iff (!rstn)
    sel_i.dir[1] && ocode[1] == 3'b000
    |=> pin_out[1] == $past(sel_i.out_vals[1]))
    else $error("pin 1 general output wrong");

  // Pin 2 general output shows its value bit
  gp_output2_a: assert property (@(posedge clk) disable iff (!rstn)
    sel_i.dir[2] && ocode[2] == 3'b000
    |=> pin_out[2] == $past(sel_i.out_vals[2]))
    else $error("pin 2 general output wrong");

  // Pin 3 general output shows its value bit
  gp_output3_a: assert property (@(posedge clk) disable iff (!rstn)
    sel_i.dir[3] && ocode[3] == 3'b000
    |=> pin_out[3] == $past(sel_i.out_vals[3]))
    else $error("pin 3 general output wrong");

  // Reserved output codes hold pin 0 low, still driven
  out_rsvd0_a: assert property (@(posedge clk) disable iff (!rstn)
    sel_i.dir[0] && ocode[0] > 3'b001
    |=> !pin_out[0] && !pin_oe_n[0])
    else $error("pin 0 reserved output not low");

  // Reserved output codes hold pin 1 low, still driven
  out_rsvd1_a: assert property (@(posedge clk) disable iff (!rstn)
    sel_i.dir[1] && ocode[1] > 3'b001
    |=> !pin_out[1] && !pin_oe_n[1])
    else $error("pin 1 reserved output not low");

  // Reserved output codes hold pin 2 low, still driven
  out_rsvd2_a: assert property (@(posedge clk) disable iff (!rstn)
    sel_i.dir[2] && ocode[2] > 3'b001
    |=> !pin_out[2] && !pin_oe_n[2])
    else $error("pin 2 reserved output not low");

  // Reserved output codes hold pin 3 low, still driven
  out_rsvd3_a: assert property (@(posedge clk) disable iff (!rstn)
    sel_i.dir[3] && ocode[3] > 3'b001
    |=> !pin_out[3] && !pin_oe_n[3])
    else $error("pin 3 reserved output not low");

  // Pin 0 left undriven in input mode
  in_undriven0_a: assert property (@(posedge clk) disable iff (!rstn)
    !sel_i.dir[0] |=> pin_oe_n[0])
    else $error("input pin 0 driven");

  // Pin 1 left undriven in input mode
  in_undriven1_a: assert property (@(posedge clk) disable iff (!rstn)
    !sel_i.dir[1] |=> pin_oe_n[1])
    else $error("input pin 1 driven");

  // Pin 3 left undriven in input mode
  in_undriven3_a: assert property (@(posedge clk) disable iff (!rstn)
    !sel_i.dir[3] |=> pin_oe_n[3])
    else $error("input pin 3 driven");

  // Every output-mode pin is driven next cycle
  out_driven_a: assert property (@(posedge clk) disable iff (!rstn)
    sel_i.dir != 4'h0 |=> (pin_oe_n & $past(sel_i.dir)) == 4'h0)
    else $error("output pin not driven");

  // General input on pin 0 readable two cycles later
  gp_input0_a: assert property (@(posedge clk) disable iff (!rstn)
    (!sel_i.dir[0] && icode[0] == 3'b000 && reg_addr == 10'h20C) ##1
    (reg_addr == 10'h20C) |=> reg_rdata[0] == $past(pin_in[0], 2))
    else $error("general input 0 not readable");

  // General input on pin 1 readable two cycles later
  gp_input1_a: assert property (@(posedge clk) disable iff (!rstn)
    (!sel_i.dir[1] && icode[1] == 3'b000 && reg_addr == 10'h20C) ##1
    (reg_addr == 10'h20C) |=> reg_rdata[1] == $past(pin_in[1], 2))
    else $error("general input 1 not readable");

  // General input on pin 2 readable two cycles later
  gp_input2_a: assert property (@(posedge clk) disable iff (!rstn)
    (!sel_i.dir[2] && icode[2] == 3'b000 && reg_addr == 10'h20C) ##1
    (reg_addr == 10'h20C) |=> reg_rdata[2] == $past(pin_in[2], 2))
    else $error("general input 2 not readable");

  // Pin 3 with a reserved input code reads zero
  pin3_rsvd_a: assert property (@(posedge clk) disable iff (!rstn)
    (!sel_i.dir[3] && icode[3] != 3'b000 && reg_addr == 10'h20C) ##1
    (reg_addr == 10'h20C) |=> !reg_rdata[3])
    else $error("pin 3 reserved code reads one");

  // Output-mode pin 0 reads zero in the input register
  out_reads0_a: assert property (@(posedge clk) disable iff (!rstn)
    (sel_i.dir[0] && reg_addr == 10'h20C) ##1
    (reg_addr == 10'h20C) |=> !reg_rdata[0])
    else $error("output pin 0 read as input");

  // Enable select bit 0 holds while pin 0 does not feed it
  oe_hold0_a: assert property (@(posedge clk) disable iff (!rstn)
    !(!sel_i.dir[0] && icode[0] == 3'b001)
    |=> $stable(output_enable_select[0]))
    else $error("enable select 0 moved");

  // Enable select bit 1 holds while pin 1 does not feed it
  oe_hold1_a: assert property (@(posedge clk) disable iff (!rstn)
    !(!sel_i.dir[1] && icode[1] == 3'b001)
    |=> $stable(output_enable_select[1]))
    else $error("enable select 1 moved");

  // Reference select holds while pin 2 does not feed it
  ref_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    !(!sel_i.dir[2] && icode[2] == 3'b001)
    |=> $stable(manual_reference_select))
    else $error("reference select moved");

  // Reset releases every pin and clears the selects
  reset_out_a: assert property (@(posedge clk)
    !rstn |=> pin_oe_n == 4'hF && pin_out == 4'h0 &&
    output_enable_select == 2'b00 && !manual_reference_select)
    else $error("outputs not at reset values");
endmodule
